// ===== rtl/tpac_map.svh
// Register map, field positions, reset values and fixed codes of the alarm conditioner
`ifndef TPAC_MAP_SVH
`define TPAC_MAP_SVH

`define TPAC_ADDR_W        8
`define TPAC_CTRL_OFS      8'h00
`define TPAC_COND_OFS      8'h04
`define TPAC_TSMASK_OFS    8'h08
`define TPAC_VLAN_OFS      8'h0C
`define TPAC_TOS_OFS       8'h10
`define TPAC_STATUS_OFS    8'h14
`define TPAC_IRQ_STAT_OFS  8'h18
`define TPAC_IRQ_MASK_OFS  8'h1C

`define TPAC_CTRL_FRAMED   0
`define TPAC_CTRL_LCAS_EN  1
`define TPAC_CTRL_PCAS_EN  2
`define TPAC_CTRL_VLAN_EN  3

`define TPAC_ALM_LOS       0
`define TPAC_ALM_LOF       1
`define TPAC_ALM_AIS       2
`define TPAC_ALM_FAIL      3
`define TPAC_ALM_JBUND     4
`define TPAC_ALM_JBOVR     5

`define TPAC_CTRL_RST      4'h0
`define TPAC_LCOND_RST     8'hFF
`define TPAC_PCOND_RST     8'hFF
`define TPAC_ABCD_RST      4'hF
`define TPAC_TSMASK_RST    32'hFFFFFFFE
`define TPAC_VID_RST       12'h001
`define TPAC_PCP_RST       3'h0
`define TPAC_TOS_RST       8'h00

`define TPAC_AIS_BYTE      8'hFF
`define TPAC_FAS_BYTE      8'h1B
`define TPAC_NFAS_BYTE     8'h40
`define TPAC_VLAN_TPID     16'h8100
`define TPAC_UDP_DPORT     16'h085E

`endif

// ===== rtl/tpac_pkg.sv
// Types of the alarm conditioner: state records of the top and the synchroniser
package tpac_pkg;

	typedef struct packed {
		logic s1;
		logic s2;
		logic s3;
		logic q;
	} tpac_sync_t;

	typedef struct packed {
		logic        framed;
		logic        lcas_en;
		logic        pcas_en;
		logic        vlan_en;
		logic [7:0]  lcond;
		logic [3:0]  labcd;
		logic [7:0]  pcond;
		logic [3:0]  pabcd;
		logic [31:0] tsmask;
		logic [11:0] vid;
		logic [2:0]  pcp;
		logic [7:0]  tos;
		logic [5:0]  irq_stat;
		logic [5:0]  irq_mask;
		logic [5:0]  alarm_prev;
		logic [31:0] prdata;
		logic        pslverr;
		logic        tx_par;
		logic        rx_par;
		logic        tx_valid;
		logic [7:0]  tx_data;
		logic [3:0]  tx_cas;
		logic        rx_valid;
		logic [7:0]  rx_data;
		logic [3:0]  rx_cas;
	} tpac_state_t;

endpackage : tpac_pkg

// ===== rtl/tpac_sync3.sv
// Three-stage pin synchroniser; output moves once stages two and three agree
module tpac_sync3
	import tpac_pkg::*;
(
	input  wire logic clk_i,
	input  wire logic rst_i,
	input  wire logic d_i,
	output logic      q_o
);

	tpac_sync_t s;
	tpac_sync_t next_s;

	always_comb begin
		next_s    = s;
		next_s.s1 = d_i;
		next_s.s2 = s.s1;
		next_s.s3 = s.s2;
		// Stage one feeds stage two only
		if (s.s2 == s.s3) begin
			next_s.q = s.s3;
		end
	end

	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			s <= '0;
		end else begin
			s <= next_s;
		end
	end

	assign q_o = s.q;

endmodule : tpac_sync3

// ===== rtl/tpac_top.sv
// Alarm conditioning and packet tagging for a TDM stream carried over packets
//
// Chosen here: the register offsets and register access over APB.
`include "tpac_map.svh"

module tpac_top
	import tpac_pkg::*;
(
	input  wire logic                   MCLK_I,
	input  wire logic                   RST_I,
	input  wire logic                   PSEL_I,
	input  wire logic                   PENABLE_I,
	input  wire logic                   PWRITE_I,
	input  wire logic [`TPAC_ADDR_W-1:0] PADDR_I,
	input  wire logic [31:0]            PWDATA_I,
	output logic      [31:0]            PRDATA_O,
	output logic                        PREADY_O,
	output logic                        PSLVERR_O,
	output logic                        IRQ_O,
	input  wire logic                   LOS_I,
	input  wire logic                   LOF_I,
	input  wire logic                   AIS_I,
	input  wire logic                   LOCAL_FAIL_I,
	input  wire logic                   JB_UNDER_I,
	input  wire logic                   JB_OVER_I,
	input  wire logic                   TDM_RX_VALID_I,
	input  wire logic [4:0]             TDM_RX_TS_I,
	input  wire logic [7:0]             TDM_RX_DATA_I,
	input  wire logic [3:0]             TDM_RX_CAS_I,
	output logic                        PKT_TX_VALID_O,
	output logic      [7:0]             PKT_TX_DATA_O,
	output logic      [3:0]             PKT_TX_CAS_O,
	input  wire logic                   PKT_RX_VALID_I,
	input  wire logic [4:0]             PKT_RX_TS_I,
	input  wire logic [7:0]             PKT_RX_DATA_I,
	input  wire logic [3:0]             PKT_RX_CAS_I,
	output logic                        TDM_TX_VALID_O,
	output logic      [7:0]             TDM_TX_DATA_O,
	output logic      [3:0]             TDM_TX_CAS_O,
	output logic                        HDR_VLAN_EN_O,
	output logic      [31:0]            HDR_VLAN_TAG_O,
	output logic      [7:0]             HDR_TOS_O,
	output logic      [15:0]            HDR_UDP_DPORT_O
);

	tpac_state_t s;
	tpac_state_t next_s;
	logic [5:0]  alarm;
	logic        line_alarm;
	logic        pkt_fault;
	logic        apb_setup;
	logic        apb_wr;
	logic [5:0]  irq_clr;

	function automatic logic [7:0] frame_byte(input logic odd);
		return odd ? `TPAC_NFAS_BYTE : `TPAC_FAS_BYTE;
	endfunction : frame_byte

	// Line alarms arrive from the line interface pins
	tpac_sync3 u_sync_los (
		.clk_i (MCLK_I),
		.rst_i (RST_I),
		.d_i   (LOS_I),
		.q_o   (alarm[`TPAC_ALM_LOS])
	);
	tpac_sync3 u_sync_lof (
		.clk_i (MCLK_I),
		.rst_i (RST_I),
		.d_i   (LOF_I),
		.q_o   (alarm[`TPAC_ALM_LOF])
	);
	tpac_sync3 u_sync_ais (
		.clk_i (MCLK_I),
		.rst_i (RST_I),
		.d_i   (AIS_I),
		.q_o   (alarm[`TPAC_ALM_AIS])
	);

	// Packet-side faults come from logic on this clock
	assign alarm[`TPAC_ALM_FAIL]  = LOCAL_FAIL_I;
	assign alarm[`TPAC_ALM_JBUND] = JB_UNDER_I;
	assign alarm[`TPAC_ALM_JBOVR] = JB_OVER_I;

	assign line_alarm = alarm[`TPAC_ALM_LOS] | alarm[`TPAC_ALM_LOF] | alarm[`TPAC_ALM_AIS];
	assign pkt_fault  = alarm[`TPAC_ALM_FAIL] | alarm[`TPAC_ALM_JBUND] | alarm[`TPAC_ALM_JBOVR];
	assign apb_setup  = PSEL_I & ~PENABLE_I;
	assign apb_wr     = PSEL_I & PENABLE_I & PWRITE_I;
	assign irq_clr    = (apb_wr && PADDR_I == `TPAC_IRQ_STAT_OFS) ? PWDATA_I[5:0] : 6'h00;

	always_comb begin
		next_s = s;

		// Register writes take effect at the access edge
		if (apb_wr) begin
			case (PADDR_I)
				`TPAC_CTRL_OFS: begin
					next_s.framed  = PWDATA_I[`TPAC_CTRL_FRAMED];
					next_s.lcas_en = PWDATA_I[`TPAC_CTRL_LCAS_EN];
					next_s.pcas_en = PWDATA_I[`TPAC_CTRL_PCAS_EN];
					next_s.vlan_en = PWDATA_I[`TPAC_CTRL_VLAN_EN];
				end
				`TPAC_COND_OFS: begin
					next_s.lcond = PWDATA_I[7:0];
					next_s.labcd = PWDATA_I[11:8];
					next_s.pcond = PWDATA_I[23:16];
					next_s.pabcd = PWDATA_I[27:24];
				end
				`TPAC_TSMASK_OFS: begin
					next_s.tsmask = PWDATA_I;
				end
				`TPAC_VLAN_OFS: begin
					next_s.vid = PWDATA_I[11:0];
					next_s.pcp = PWDATA_I[14:12];
				end
				`TPAC_TOS_OFS: begin
					next_s.tos = PWDATA_I[7:0];
				end
				`TPAC_IRQ_MASK_OFS: begin
					next_s.irq_mask = PWDATA_I[5:0];
				end
				default: begin
				end
			endcase
		end

		// Read data is latched in setup so the access phase needs no wait
		if (apb_setup) begin
			next_s.pslverr = 1'b0;
			case (PADDR_I)
				`TPAC_CTRL_OFS:     next_s.prdata = {28'h0000000, s.vlan_en, s.pcas_en,
				                                     s.lcas_en, s.framed};
				`TPAC_COND_OFS:     next_s.prdata = {4'h0, s.pabcd, s.pcond,
				                                     4'h0, s.labcd, s.lcond};
				`TPAC_TSMASK_OFS:   next_s.prdata = s.tsmask;
				`TPAC_VLAN_OFS:     next_s.prdata = {17'h00000, s.pcp, s.vid};
				`TPAC_TOS_OFS:      next_s.prdata = {24'h000000, s.tos};
				`TPAC_STATUS_OFS:   next_s.prdata = {24'h000000, pkt_fault, line_alarm, alarm};
				`TPAC_IRQ_STAT_OFS: next_s.prdata = {26'h0000000, s.irq_stat};
				`TPAC_IRQ_MASK_OFS: next_s.prdata = {26'h0000000, s.irq_mask};
				default: begin
					next_s.prdata  = 32'h00000000;
					next_s.pslverr = 1'b1;
				end
			endcase
		end

		// Rising alarm edges are sticky; a new edge beats a same-cycle clear
		next_s.alarm_prev = alarm;
		next_s.irq_stat   = (s.irq_stat & ~irq_clr) | (alarm & ~s.alarm_prev);

		// Toward the packet network
		next_s.tx_valid = TDM_RX_VALID_I;
		if (TDM_RX_VALID_I) begin
			next_s.tx_data = TDM_RX_DATA_I;
			next_s.tx_cas  = TDM_RX_CAS_I;
			if (!s.framed) begin
				if (alarm[`TPAC_ALM_LOS]) begin
					next_s.tx_data = `TPAC_AIS_BYTE;
				end
			end else if (TDM_RX_TS_I == 5'h00) begin
				next_s.tx_par = ~s.tx_par;
				if (line_alarm) begin
					next_s.tx_data = frame_byte(s.tx_par);
				end
			end else if (line_alarm && s.tsmask[TDM_RX_TS_I]) begin
				next_s.tx_data = s.lcond;
				if (s.lcas_en) begin
					next_s.tx_cas = s.labcd;
				end
			end
		end

		// Toward the local TDM device
		next_s.rx_valid = PKT_RX_VALID_I;
		if (PKT_RX_VALID_I) begin
			next_s.rx_data = PKT_RX_DATA_I;
			next_s.rx_cas  = PKT_RX_CAS_I;
			if (!s.framed) begin
				if (pkt_fault) begin
					next_s.rx_data = `TPAC_AIS_BYTE;
				end
			end else if (PKT_RX_TS_I == 5'h00) begin
				next_s.rx_par = ~s.rx_par;
				if (pkt_fault) begin
					next_s.rx_data = frame_byte(s.rx_par);
				end
			end else if (pkt_fault && s.tsmask[PKT_RX_TS_I]) begin
				next_s.rx_data = s.pcond;
				if (s.pcas_en) begin
					next_s.rx_cas = s.pabcd;
				end
			end
		end
		// substitution follows live alarm levels, so it ends with them
	end

	always_ff @(posedge MCLK_I or posedge RST_I) begin
		if (RST_I) begin
			s          <= '0;
			s.framed   <= 1'(`TPAC_CTRL_RST >> `TPAC_CTRL_FRAMED);
			s.lcas_en  <= 1'(`TPAC_CTRL_RST >> `TPAC_CTRL_LCAS_EN);
			s.pcas_en  <= 1'(`TPAC_CTRL_RST >> `TPAC_CTRL_PCAS_EN);
			s.vlan_en  <= 1'(`TPAC_CTRL_RST >> `TPAC_CTRL_VLAN_EN);
			s.lcond    <= `TPAC_LCOND_RST;
			s.pcond    <= `TPAC_PCOND_RST;
			s.labcd    <= `TPAC_ABCD_RST;
			s.pabcd    <= `TPAC_ABCD_RST;
			s.tsmask   <= `TPAC_TSMASK_RST;
			s.vid      <= `TPAC_VID_RST;
			s.pcp      <= `TPAC_PCP_RST;
			s.tos      <= `TPAC_TOS_RST;
		end else begin
			s <= next_s;
		end
	end

	assign PREADY_O        = PSEL_I & PENABLE_I;
	assign PRDATA_O        = s.prdata;
	assign PSLVERR_O       = s.pslverr & PSEL_I & PENABLE_I;
	assign IRQ_O           = |(s.irq_stat & s.irq_mask);
	assign PKT_TX_VALID_O  = s.tx_valid;
	assign PKT_TX_DATA_O   = s.tx_data;
	assign PKT_TX_CAS_O    = s.tx_cas;
	assign TDM_TX_VALID_O  = s.rx_valid;
	assign TDM_TX_DATA_O   = s.rx_data;
	assign TDM_TX_CAS_O    = s.rx_cas;
	// tag built from vid and priority
	assign HDR_VLAN_EN_O   = s.vlan_en;
	assign HDR_VLAN_TAG_O  = {`TPAC_VLAN_TPID, s.pcp, 1'b0, s.vid};
	assign HDR_TOS_O       = s.tos;
	assign HDR_UDP_DPORT_O = `TPAC_UDP_DPORT;

	// Line alarms lag their pins by the synchroniser, so checks use synced levels
	default clocking cb @(posedge MCLK_I); endclocking
	default disable iff (RST_I);

	a_los_ais_out: assert property (
		!s.framed && alarm[`TPAC_ALM_LOS] && TDM_RX_VALID_I
		|=> PKT_TX_VALID_O && PKT_TX_DATA_O == `TPAC_AIS_BYTE)
		else $error("LOS did not give all ones toward network");

	a_unframed_pass: assert property (
		!s.framed && !alarm[`TPAC_ALM_LOS] && TDM_RX_VALID_I
		|=> PKT_TX_DATA_O == $past(TDM_RX_DATA_I) && PKT_TX_CAS_O == $past(TDM_RX_CAS_I))
		else $error("Unframed data not passed unchanged");

	a_line_cond: assert property (
		s.framed && line_alarm && TDM_RX_VALID_I && TDM_RX_TS_I != 5'h00
		&& s.tsmask[TDM_RX_TS_I] |=> PKT_TX_DATA_O == $past(s.lcond))
		else $error("Line conditioning byte missing");

	a_line_abcd: assert property (
		s.framed && s.lcas_en && line_alarm && TDM_RX_VALID_I && TDM_RX_TS_I != 5'h00
		&& s.tsmask[TDM_RX_TS_I] |=> PKT_TX_CAS_O == $past(s.labcd))
		else $error("Line ABCD pattern missing");

	a_frame_kept: assert property (
		s.framed && pkt_fault && PKT_RX_VALID_I && PKT_RX_TS_I == 5'h00
		|=> TDM_TX_DATA_O inside {`TPAC_FAS_BYTE, `TPAC_NFAS_BYTE})
		else $error("Framing lost under conditioning");

	a_fault_ais: assert property (
		!s.framed && pkt_fault && PKT_RX_VALID_I |=> TDM_TX_DATA_O == `TPAC_AIS_BYTE)
		else $error("Fault did not give AIS toward local TDM");

	a_bundle_cond: assert property (
		s.framed && pkt_fault && PKT_RX_VALID_I && PKT_RX_TS_I != 5'h00
		&& s.tsmask[PKT_RX_TS_I] |=> TDM_TX_DATA_O == $past(s.pcond))
		else $error("Bundle conditioning wrong");

	a_bundle_only: assert property (
		s.framed && pkt_fault && PKT_RX_VALID_I && PKT_RX_TS_I != 5'h00
		&& !s.tsmask[PKT_RX_TS_I] |=> TDM_TX_DATA_O == $past(PKT_RX_DATA_I))
		else $error("Timeslot outside the bundle was conditioned");

	a_pkt_abcd: assert property (
		s.framed && s.pcas_en && pkt_fault && PKT_RX_VALID_I && PKT_RX_TS_I != 5'h00
		&& s.tsmask[PKT_RX_TS_I] |=> TDM_TX_CAS_O == $past(s.pabcd))
		else $error("Packet ABCD pattern missing");

	a_vlan_tag: assert property (
		HDR_VLAN_TAG_O[31:16] == `TPAC_VLAN_TPID && HDR_VLAN_TAG_O[15:13] == s.pcp
		&& HDR_VLAN_TAG_O[11:0] == s.vid)
		else $error("VLAN tag malformed");

	a_tos_write: assert property (
		apb_wr && PADDR_I == `TPAC_TOS_OFS |=> HDR_TOS_O == 8'($past(PWDATA_I)))
		else $error("TOS write not applied");

	a_udp_port: assert property (
		HDR_UDP_DPORT_O == 16'd2142)
		else $error("UDP destination port wrong");

	a_rx_resume: assert property (
		!pkt_fault && PKT_RX_VALID_I |=> TDM_TX_DATA_O == $past(PKT_RX_DATA_I)
		|| ($past(s.framed) && $past(PKT_RX_TS_I) == 5'h00))
		else $error("Data not resumed after fault cleared");

	a_tx_resume: assert property (
		!line_alarm && TDM_RX_VALID_I |=> PKT_TX_DATA_O == $past(TDM_RX_DATA_I))
		else $error("Data toward network not resumed after alarm cleared");

	a_irq_level: assert property (
		$rose(alarm[`TPAC_ALM_FAIL]) && s.irq_mask[`TPAC_ALM_FAIL] |=> IRQ_O)
		else $error("Masked-in event raised no interrupt");

	// A clear with no new edge in the same cycle must empty the bit
	a_irq_w1c: assert property (
		apb_wr && PADDR_I == `TPAC_IRQ_STAT_OFS && PWDATA_I[`TPAC_ALM_LOS] && !alarm[`TPAC_ALM_LOS]
		|=> !s.irq_stat[`TPAC_ALM_LOS])
		else $error("Status bit not cleared by writing one");

	c_los_unframed: cover property (!s.framed && alarm[`TPAC_ALM_LOS] && TDM_RX_VALID_I);
	c_framed_cond:  cover property (s.framed && line_alarm && TDM_RX_VALID_I);
	c_jb_fault:     cover property (s.framed && pkt_fault && PKT_RX_VALID_I ##1 !pkt_fault);
	c_irq:          cover property ($rose(IRQ_O));
	c_rx_frame:     cover property (s.framed && pkt_fault && PKT_RX_VALID_I && PKT_RX_TS_I == 5'h00);

endmodule : tpac_top

// ===== testbench/tpac_far_model.sv
// Far-side source: local TDM equipment and the remote packet gateway
module tpac_far_model (
	input  wire logic       clk_i,
	output logic            tdm_valid_o,
	output logic [4:0]      tdm_ts_o,
	output logic [7:0]      tdm_data_o,
	output logic [3:0]      tdm_cas_o,
	output logic            pkt_valid_o,
	output logic [4:0]      pkt_ts_o,
	output logic [7:0]      pkt_data_o,
	output logic [3:0]      pkt_cas_o
);
	timeunit 1ns;
	timeprecision 1ns;

	initial begin
		{tdm_valid_o, tdm_ts_o, tdm_data_o, tdm_cas_o} = 18'h0;
		{pkt_valid_o, pkt_ts_o, pkt_data_o, pkt_cas_o} = 18'h0;
	end

	// One byte with CAS, valid for exactly one edge
	task send(input logic p, input logic [4:0] ts, input logic [7:0] d, input logic [3:0] c);
		@(posedge clk_i);
		if (p) begin
			{pkt_valid_o, pkt_ts_o, pkt_data_o, pkt_cas_o} <= {1'b1, ts, d, c};
		end else begin
			{tdm_valid_o, tdm_ts_o, tdm_data_o, tdm_cas_o} <= {1'b1, ts, d, c};
		end
		@(posedge clk_i);
		// Released lines invert so a stale byte never looks valid
		if (p) begin
			{pkt_valid_o, pkt_ts_o, pkt_data_o, pkt_cas_o} <= {1'b0, ~ts, ~d, ~c};
		end else begin
			{tdm_valid_o, tdm_ts_o, tdm_data_o, tdm_cas_o} <= {1'b0, ~ts, ~d, ~c};
		end
	endtask : send
endmodule : tpac_far_model

// ===== testbench/tb_top.sv
// Self-checking bench of the alarm conditioner
`include "tpac_map.svh"

module tb_top;
	timeunit 1ns;
	timeprecision 1ns;

	logic        clk, rst, psel, pen, pwr;
	logic [7:0]  padr;
	logic [31:0] pwd, prdata, htag;
	logic [5:0]  alm_v;
	logic        pready, pslverr, irq, ptv, ttv, hen, rtv, rpv;
	logic [7:0]  ptd, ttd, htos, rtd, rpd;
	logic [3:0]  ptc, ttc, rtc, rpc;
	logic [4:0]  rts, rps;
	logic [15:0] hport;
	int          failures, n_tests;

	tpac_far_model far_u (.clk_i(clk), .tdm_valid_o(rtv), .tdm_ts_o(rts), .tdm_data_o(rtd),
		.tdm_cas_o(rtc), .pkt_valid_o(rpv), .pkt_ts_o(rps), .pkt_data_o(rpd), .pkt_cas_o(rpc));

	tpac_top dut_u (.MCLK_I(clk), .RST_I(rst), .PSEL_I(psel), .PENABLE_I(pen), .PWRITE_I(pwr),
		.PADDR_I(padr), .PWDATA_I(pwd), .PRDATA_O(prdata), .PREADY_O(pready),
		.PSLVERR_O(pslverr), .IRQ_O(irq), .LOS_I(alm_v[0]), .LOF_I(alm_v[1]), .AIS_I(alm_v[2]),
		.LOCAL_FAIL_I(alm_v[3]), .JB_UNDER_I(alm_v[4]), .JB_OVER_I(alm_v[5]),
		.TDM_RX_VALID_I(rtv), .TDM_RX_TS_I(rts), .TDM_RX_DATA_I(rtd), .TDM_RX_CAS_I(rtc),
		.PKT_TX_VALID_O(ptv), .PKT_TX_DATA_O(ptd), .PKT_TX_CAS_O(ptc),
		.PKT_RX_VALID_I(rpv), .PKT_RX_TS_I(rps), .PKT_RX_DATA_I(rpd), .PKT_RX_CAS_I(rpc),
		.TDM_TX_VALID_O(ttv), .TDM_TX_DATA_O(ttd), .TDM_TX_CAS_O(ttc),
		.HDR_VLAN_EN_O(hen), .HDR_VLAN_TAG_O(htag), .HDR_TOS_O(htos), .HDR_UDP_DPORT_O(hport));

	always #10 clk = ~clk;

	task close_out;
		$display("tests=%0d failures=%0d", n_tests, failures);
		if (failures == 0 && n_tests > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask : close_out

	task chk(input string nm, input logic [31:0] s, input logic [31:0] e);
		n_tests++;
		if (s !== e) begin
			failures++;
			$display("CHECK FAILED %s exp=%h seen=%h", nm, e, s);
		end
	endtask : chk

	task apb(input logic w, input logic [7:0] a, input logic [31:0] wd,
		output logic [31:0] rd, output logic er);
		int n;
		@(posedge clk);
		{psel, pen, pwr, padr, pwd} <= {1'b1, 1'b0, w, a, wd};
		@(posedge clk);
		pen <= 1'b1;
		n = 0;
		do begin
			@(posedge clk);
			n++;
		end while (pready !== 1'b1 && n < 50);
		if (n >= 50) failures++;
		rd = prdata;
		er = pslverr;
		{psel, pen} <= 2'h0;
		#1;
	endtask : apb

	task wr(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] r;
		logic e;
		apb(1'b1, a, d, r, e);
	endtask : wr

	task rdc(input string nm, input logic [7:0] a, input logic [31:0] x);
		logic [31:0] r;
		logic e;
		apb(1'b0, a, 32'h0, r, e);
		chk(nm, r, x);
	endtask : rdc

	// Line alarms pass a three-stage synchroniser, so settle well past it
	task alm(input logic [5:0] v);
		@(posedge clk);
		alm_v <= v;
		repeat (6) @(posedge clk);
		#1;
	endtask : alm

	task st(input logic p, input logic [4:0] ts, input logic [7:0] d, input logic [3:0] c,
		input logic [7:0] ed, input logic [3:0] ec);
		far_u.send(p, ts, d, c);
		#1;
		if (p) begin
			chk("tdm tx", {ttv, ttd, ttc}, {1'b1, ed, ec});
		end else begin
			chk("pkt tx", {ptv, ptd, ptc}, {1'b1, ed, ec});
		end
	endtask : st

	task t_regs;
		logic [31:0] d;
		logic e;
		rdc("ctrl", `TPAC_CTRL_OFS, 32'h0);
		rdc("cond", `TPAC_COND_OFS, {4'h0, `TPAC_ABCD_RST, `TPAC_PCOND_RST, 4'h0,
			`TPAC_ABCD_RST, `TPAC_LCOND_RST});
		rdc("tsmask", `TPAC_TSMASK_OFS, `TPAC_TSMASK_RST);
		rdc("vlan", `TPAC_VLAN_OFS, {17'h0, `TPAC_PCP_RST, `TPAC_VID_RST});
		rdc("tos", `TPAC_TOS_OFS, 32'h0);
		rdc("imask", `TPAC_IRQ_MASK_OFS, 32'h0);
		wr(`TPAC_STATUS_OFS, 32'hFF);
		rdc("status ro", `TPAC_STATUS_OFS, 32'h0);
		apb(1'b0, 8'h20, 32'h0, d, e);
		chk("unmapped err", {31'h0, e}, 32'h1);
		chk("unmapped rd", d, 32'h0);
	endtask : t_regs

	task t_hdr;
		chk("dport", hport, 32'h085E);
		wr(`TPAC_VLAN_OFS, 32'h5123);
		wr(`TPAC_TOS_OFS, 32'hB0);
		wr(`TPAC_CTRL_OFS, 32'h8);
		chk("vlan en", hen, 32'h1);
		chk("vlan tag", htag, {`TPAC_VLAN_TPID, 3'h5, 1'b0, 12'h123});
		chk("tos", htos, 32'hB0);
	endtask : t_hdr

	task t_uf;
		st(0, 5'h0, 8'h1B, 4'h5, 8'h1B, 4'h5);
		alm(6'h2);
		st(0, 5'h0, 8'h1B, 4'h5, 8'h1B, 4'h5);
		alm(6'h1);
		st(0, 5'h9, 8'h3C, 4'h5, `TPAC_AIS_BYTE, 4'h5);
		for (int i = 3; i < 6; i++) begin
			alm(6'h1 << i);
			st(1, 5'h7, 8'h3C, 4'h6, `TPAC_AIS_BYTE, 4'h6);
		end
		alm(6'h0);
		st(0, 5'h9, 8'h3C, 4'h5, 8'h3C, 4'h5);
		st(1, 5'h7, 8'h3C, 4'h6, 8'h3C, 4'h6);
	endtask : t_uf

	task t_irq;
		wr(`TPAC_IRQ_STAT_OFS, 32'h3F);
		wr(`TPAC_IRQ_MASK_OFS, 32'h1);
		chk("irq idle", irq, 32'h0);
		alm(6'h2);
		chk("irq masked", irq, 32'h0);
		alm(6'h1);
		chk("irq set", irq, 32'h1);
		rdc("status", `TPAC_STATUS_OFS, 32'h41);
		alm(6'h0);
		chk("irq sticky", irq, 32'h1);
		wr(`TPAC_IRQ_STAT_OFS, 32'h1);
		rdc("irq stat", `TPAC_IRQ_STAT_OFS, 32'h2);
		chk("irq clear", irq, 32'h0);
	endtask : t_irq

	// Two timeslot 0 bytes in a row must carry both frame words
	task fr0(input logic p);
		logic [7:0] a;
		logic [7:0] b;
		far_u.send(p, 5'h0, 8'h77, 4'h0);
		#1;
		a = p ? ttd : ptd;
		far_u.send(p, 5'h0, 8'h77, 4'h0);
		#1;
		b = p ? ttd : ptd;
		chk("ts0 frame", {31'h0, (a === `TPAC_FAS_BYTE && b === `TPAC_NFAS_BYTE) ||
			(a === `TPAC_NFAS_BYTE && b === `TPAC_FAS_BYTE)}, 32'h1);
	endtask : fr0

	task t_fr;
		wr(`TPAC_CTRL_OFS, 32'h7);
		wr(`TPAC_COND_OFS, 32'h0CA5_035A);
		wr(`TPAC_TSMASK_OFS, 32'h4);
		for (int i = 0; i < 3; i++) begin
			alm(6'h1 << i);
			st(0, 5'h2, 8'h11, 4'h9, 8'h5A, 4'h3);
			st(0, 5'h3, 8'h22, 4'h9, 8'h22, 4'h9);
		end
		fr0(1'b0);
		for (int i = 3; i < 6; i++) begin
			alm(6'h1 << i);
			st(1, 5'h2, 8'h11, 4'h9, 8'hA5, 4'hC);
			st(1, 5'h3, 8'h22, 4'h9, 8'h22, 4'h9);
		end
		fr0(1'b1);
		alm(6'h0);
		st(0, 5'h2, 8'h11, 4'h9, 8'h11, 4'h9);
		st(1, 5'h2, 8'h11, 4'h9, 8'h11, 4'h9);
	endtask : t_fr

	// Mid-run reset brings registers and the interrupt back to rest
	task t_rst;
		@(posedge clk);
		rst <= 1'b1;
		repeat (2) @(posedge clk);
		rst <= 1'b0;
		rdc("ctrl rst", `TPAC_CTRL_OFS, {28'h0, `TPAC_CTRL_RST});
		rdc("tos rst", `TPAC_TOS_OFS, {24'h0, `TPAC_TOS_RST});
		rdc("tsmask rst", `TPAC_TSMASK_OFS, `TPAC_TSMASK_RST);
		chk("hen rst", hen, 32'h0);
		chk("irq rst", irq, 32'h0);
	endtask : t_rst

	initial begin
		{clk, rst, psel, pen, pwr, padr, pwd, alm_v} = {2'b01, 3'h0, 8'h0, 32'h0, 6'h0};
		failures = 0;
		n_tests = 0;
		repeat (16) @(posedge clk);
		rst <= 1'b0;
		t_regs;
		t_hdr;
		t_uf;
		t_irq;
		t_fr;
		t_rst;
		close_out;
	end

	initial begin
		repeat (20000) @(posedge clk);
		failures++;
		close_out;
	end
endmodule : tb_top
